// ==== include/jss_pkg.sv ====
// types shared by the jtag scan sequencer
package jss_pkg;

  typedef enum logic [3:0] {
    JSS_OP_END      = 4'h0,
    JSS_OP_IR       = 4'h1,
    JSS_OP_DR       = 4'h2,
    JSS_OP_WAIT     = 4'h3,
    JSS_OP_TRST_ON  = 4'h4,
    JSS_OP_TRST_OFF = 4'h5,
    JSS_OP_RST_ON   = 4'h6,
    JSS_OP_RST_OFF  = 4'h7,
    JSS_OP_BURST_HI = 4'h8,
    JSS_OP_BURST_LO = 4'h9
  } jss_op_t;

  typedef struct packed {
    jss_op_t     op;
    logic [15:0] n;
    logic [31:0] word;
  } jss_cmd_t;

  typedef struct packed {
    logic        hard_reset;
    logic        catch_reset;
    logic        trst_push_pull;
    logic        pre_en;
    logic        post_en;
    logic [15:0] reset_ms;
    logic [15:0] wakeup_ms;
  } jss_cfg_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } jss_jtag_t;

  typedef struct packed {
    logic        bypass_ok;
    logic        dbg_ok;
    logic [31:0] idcode;
  } jss_report_t;

  typedef enum logic [3:0] {
    JSS_PH_IDLE  = 4'h0,
    JSS_PH_TRST  = 4'h1,
    JSS_PH_HOLD  = 4'h3,
    JSS_PH_PRE   = 4'h2,
    JSS_PH_CHECK = 4'h6,
    JSS_PH_REL   = 4'h7,
    JSS_PH_SEE   = 4'h5,
    JSS_PH_WAKE  = 4'h4,
    JSS_PH_POST  = 4'hC,
    JSS_PH_STD   = 4'hD,
    JSS_PH_DONE  = 4'hF
  } jss_phase_t;

  typedef enum logic [2:0] {
    JSS_X_IDLE  = 3'h0,
    JSS_X_FETCH = 3'h1,
    JSS_X_DEC   = 3'h3,
    JSS_X_LD    = 3'h2,
    JSS_X_GET   = 3'h6,
    JSS_X_SCAN  = 3'h7,
    JSS_X_WAIT  = 3'h5,
    JSS_X_BURST = 3'h4
  } jss_exec_t;

endpackage

// ==== include/jss_regs.svh ====
// timing, field and layout constants of the jtag scan sequencer
`ifndef JSS_REGS_SVH
`define JSS_REGS_SVH
`define JSS_CLK_NS         25
`define JSS_US_NS          1000
`define JSS_MS_NS          1000000
`define JSS_TRST_PULSE_US  1
`define JSS_TCK_HALF       4
`define JSS_OP_HI          31
`define JSS_OP_LO          28
`define JSS_N_HI           15
`define JSS_N_LO           0
`define JSS_SCAN_MIN       1
`define JSS_SCAN_MAX       256
`define JSS_IR_HDR         4
`define JSS_DR_HDR         3
`define JSS_TAIL_LEN       2
`define JSS_PRE_BASE       0
`define JSS_POST_BASE      128
`define JSS_IR_LEN         5
`define JSS_IDCODE_IR      32'h0000001E
`define JSS_DBG_IR         32'h00000008
`define JSS_CATCH_IR       32'h00000009
`define JSS_CATCH_MASK     32'h00000001
`define JSS_HALT_BIT       1
`endif

// ==== rtl/jss_script_mem.sv ====
// script word memory with registered read data
`timescale 1ns/100ps
module jss_script_mem #(
  parameter int AW = 8,
  parameter int DW = 32
) (
  input  wire logic          clk_sys,
  input  wire logic          reset_n,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);
  logic [DW-1:0] mem_reg [0:(1<<AW)-1];

  // storage carries no reset so it can map onto block ram
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem_reg[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem_reg[rd_addr];
    end
  end
endmodule

// ==== rtl/jss_sequencer.sv ====
// jtag scan sequencer: reset sequence with pre and post scan scripts
`timescale 1ns/100ps
`include "jss_regs.svh"
module jss_sequencer #(
  parameter int          AW         = 8,
  parameter int          TCK_HALF   = `JSS_TCK_HALF,
  parameter logic [31:0] MS_CYCLES  = 32'(`JSS_MS_NS / `JSS_CLK_NS),
  parameter int          IR_LEN     = `JSS_IR_LEN,
  parameter logic [31:0] IDCODE_IR  = `JSS_IDCODE_IR,
  parameter logic [31:0] DBG_IR     = `JSS_DBG_IR,
  parameter logic [31:0] CATCH_IR   = `JSS_CATCH_IR,
  parameter logic [31:0] CATCH_MASK = `JSS_CATCH_MASK,
  parameter int          HALT_BIT   = `JSS_HALT_BIT
) (
  input  wire logic                 clk_sys,
  input  wire logic                 reset_n,
  input  wire jss_pkg::jss_cfg_t    cfg,
  input  wire logic                 start,
  input  wire logic                 load_we,
  input  wire logic [AW-1:0]        load_addr,
  input  wire logic [31:0]          load_data,
  input  wire logic                 tdo,
  input  wire logic                 srst_n_i,
  output jss_pkg::jss_jtag_t        jtag,
  output logic                      trst_n_o,
  output logic                      trst_n_oe,
  output logic                      srst_n_o,
  output logic                      srst_n_oe,
  output logic                      seq_busy,
  output logic                      seq_done,
  output logic                      script_err,
  output jss_pkg::jss_report_t      report
);
  localparam logic [31:0] US_CYC   = 32'(`JSS_US_NS / `JSS_CLK_NS);
  localparam logic [31:0] TRST_CYC = 32'(`JSS_TRST_PULSE_US) * US_CYC;
  localparam logic [AW-1:0] PRE_BASE  = AW'(`JSS_PRE_BASE);
  localparam logic [AW-1:0] POST_BASE = AW'(`JSS_POST_BASE);

  jss_pkg::jss_phase_t  phase_reg;
  jss_pkg::jss_exec_t   xs_reg;
  jss_pkg::jss_cmd_t    cur_reg;
  jss_pkg::jss_cmd_t    cmd_in;
  jss_pkg::jss_jtag_t   jtag_reg;
  jss_pkg::jss_report_t report_reg;
  logic [AW-1:0]        pc_reg;
  logic [15:0]          cnt_reg;
  logic [1:0]           seg_reg;
  logic [31:0]          sh_reg;
  logic [31:0]          cap_reg;
  logic [31:0]          tmr_reg;
  logic [2:0]           step_reg;
  logic                 script_reg;
  logic                 trst_on_reg;
  logic                 srst_on_reg;
  logic                 err_reg;
  logic [31:0]          rd_data;
  logic [7:0]           div_reg;
  logic                 busy_reg;
  logic                 ph_reg;
  logic                 done_reg;
  logic                 cap_bit_reg;
  logic [1:0]           tdo_sync_reg;
  logic [1:0]           srst_sync_reg;

  function automatic logic [31:0] to_cycles(input logic [15:0] n,
                                            input logic [31:0] per);
    to_cycles = 32'(n) * per;
  endfunction

  // script words are pre-tokenised: one word per colon-delimited command, scans followed by one data word per 32 bits
  function automatic jss_pkg::jss_cmd_t mem_cmd(input logic [31:0] w);
    mem_cmd.op   = jss_pkg::jss_op_t'(w[`JSS_OP_HI:`JSS_OP_LO]);
    mem_cmd.n    = w[`JSS_N_HI:`JSS_N_LO];
    mem_cmd.word = 32'h0000_0000;
  endfunction

  // standard checks and debug setup between the two scripts
  function automatic jss_pkg::jss_cmd_t std_cmd(input logic [2:0] s);
    std_cmd.n = 16'h0020;
    unique case (s)
      3'h0: std_cmd = '{jss_pkg::JSS_OP_IR, 16'(IR_LEN), 32'hFFFF_FFFF};
      3'h1: std_cmd = '{jss_pkg::JSS_OP_DR, 16'h0020, 32'hFFFF_FFFF};
      3'h2: std_cmd = '{jss_pkg::JSS_OP_IR, 16'(IR_LEN), IDCODE_IR};
      3'h3: std_cmd = '{jss_pkg::JSS_OP_DR, 16'h0020, 32'h0000_0000};
      3'h4: std_cmd = '{jss_pkg::JSS_OP_IR, 16'(IR_LEN), DBG_IR};
      3'h5: std_cmd = '{jss_pkg::JSS_OP_DR, 16'h0020,
                        32'h0000_0001 << HALT_BIT};
      3'h6: std_cmd = '{jss_pkg::JSS_OP_IR, 16'(IR_LEN), CATCH_IR};
      3'h7: std_cmd = '{jss_pkg::JSS_OP_DR, 16'h0020, CATCH_MASK};
    endcase
  endfunction

  jss_script_mem #(
    .AW (AW),
    .DW (32)
  ) u_mem (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .wr_en   (load_we),
    .wr_addr (load_addr),
    .wr_data (load_data),
    .rd_addr (pc_reg),
    .rd_data (rd_data)
  );

  // decoding
  wire        is_ir     = cur_reg.op == jss_pkg::JSS_OP_IR;
  wire [15:0] hdr_last  = is_ir ? 16'(`JSS_IR_HDR - 1) :
                                  16'(`JSS_DR_HDR - 1);
  wire        shift_end = cnt_reg == cur_reg.n - 16'h0001;
  wire [2:0]  last_step = cfg.catch_reset ? 3'h7 : 3'h5;
  wire        scan_ok   = cmd_in.n >= 16'(`JSS_SCAN_MIN) &&
                          cmd_in.n <= 16'(`JSS_SCAN_MAX);
  wire [16:0] skip_w    = (17'(cmd_in.n) + 17'h0001F) >> 5;
  wire        tmr_zero  = tmr_reg == 32'h0000_0000;
  wire        x_idle    = xs_reg == jss_pkg::JSS_X_IDLE;
  wire        half_en   = div_reg == 8'h00;
  wire        tdo_s     = tdo_sync_reg[1];
  wire        srst_seen = srst_sync_reg[1];
  wire        in_bits   = xs_reg == jss_pkg::JSS_X_SCAN ||
                          xs_reg == jss_pkg::JSS_X_BURST;
  wire        bit_req   = in_bits && !busy_reg && !done_reg;
  wire        hdr_tms   = cnt_reg == 16'h0000 ||
                          (is_ir && cnt_reg == 16'h0001);
  wire        scan_tms  = seg_reg == 2'h0 ? hdr_tms :
                          seg_reg == 2'h1 ? shift_end :
                                            cnt_reg == 16'h0000;
  wire        bit_tms   = xs_reg == jss_pkg::JSS_X_BURST ?
                          cur_reg.op == jss_pkg::JSS_OP_BURST_HI :
                          scan_tms;
  wire        bit_tdi   = xs_reg == jss_pkg::JSS_X_SCAN &&
                          seg_reg == 2'h1 && sh_reg[0];
  wire        cmd_next  = script_reg;

  assign cmd_in     = script_reg ? mem_cmd(rd_data) : std_cmd(step_reg);
  assign jtag       = jtag_reg;
  assign report     = report_reg;
  assign script_err = err_reg;
  // trst open drain unless push-pull is chosen, srst always open drain
  assign trst_n_o   = !trst_on_reg;
  assign trst_n_oe  = trst_on_reg || cfg.trst_push_pull;
  assign srst_n_o   = 1'b0;
  assign srst_n_oe  = srst_on_reg;
  assign seq_busy   = phase_reg != jss_pkg::JSS_PH_IDLE &&
                      phase_reg != jss_pkg::JSS_PH_DONE;
  assign seq_done   = phase_reg == jss_pkg::JSS_PH_DONE;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tdo_sync_reg  <= 2'h0;
      srst_sync_reg <= 2'h0;
    end else begin
      tdo_sync_reg  <= {tdo_sync_reg[0], tdo};
      srst_sync_reg <= {srst_sync_reg[0], srst_n_i};
    end
  end

  // tck engine: each bit is setup, rise with tdo sample, fall
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      div_reg     <= 8'h00;
      busy_reg    <= 1'b0;
      ph_reg      <= 1'b0;
      done_reg    <= 1'b0;
      cap_bit_reg <= 1'b0;
      jtag_reg    <= '{1'b0, 1'b1, 1'b0};
    end else begin
      div_reg  <= half_en ? 8'(TCK_HALF - 1) : div_reg - 8'h01;
      done_reg <= 1'b0;
      if (half_en && bit_req) begin
        jtag_reg.tms <= bit_tms;
        jtag_reg.tdi <= bit_tdi;
        busy_reg     <= 1'b1;
        ph_reg       <= 1'b0;
      end else if (half_en && busy_reg && !ph_reg) begin
        jtag_reg.tck <= 1'b1;
        cap_bit_reg  <= tdo_s;
        ph_reg       <= 1'b1;
      end else if (half_en && busy_reg) begin
        jtag_reg.tck <= 1'b0;
        busy_reg     <= 1'b0;
        done_reg     <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      phase_reg   <= jss_pkg::JSS_PH_IDLE;
      xs_reg      <= jss_pkg::JSS_X_IDLE;
      cur_reg     <= '0;
      pc_reg      <= '0;
      cnt_reg     <= 16'h0000;
      seg_reg     <= 2'h0;
      sh_reg      <= 32'h0000_0000;
      cap_reg     <= 32'h0000_0000;
      tmr_reg     <= 32'h0000_0000;
      step_reg    <= 3'h0;
      script_reg  <= 1'b0;
      trst_on_reg <= 1'b0;
      srst_on_reg <= 1'b0;
      err_reg     <= 1'b0;
      report_reg  <= '0;
    end else begin
      if (!tmr_zero) begin
        tmr_reg <= tmr_reg - 32'h0000_0001;
      end
      unique case (xs_reg)
        jss_pkg::JSS_X_IDLE: begin
        end
        jss_pkg::JSS_X_FETCH, jss_pkg::JSS_X_LD: begin
          pc_reg <= pc_reg + 1'b1;
          xs_reg <= xs_reg == jss_pkg::JSS_X_FETCH ?
                    jss_pkg::JSS_X_DEC : jss_pkg::JSS_X_GET;
        end
        jss_pkg::JSS_X_GET: begin
          sh_reg <= rd_data;
          xs_reg <= jss_pkg::JSS_X_SCAN;
        end
        jss_pkg::JSS_X_DEC: begin
          cur_reg <= cmd_in;
          cnt_reg <= 16'h0000;
          seg_reg <= 2'h0;
          xs_reg  <= cmd_next ? jss_pkg::JSS_X_FETCH : jss_pkg::JSS_X_IDLE;
          case (cmd_in.op)
            jss_pkg::JSS_OP_IR, jss_pkg::JSS_OP_DR: begin
              if (!scan_ok) begin
                err_reg <= 1'b1;
                pc_reg  <= pc_reg + AW'(skip_w);
              end else if (script_reg) begin
                xs_reg <= jss_pkg::JSS_X_LD;
              end else begin
                sh_reg <= cmd_in.word;
                xs_reg <= jss_pkg::JSS_X_SCAN;
              end
            end
            jss_pkg::JSS_OP_WAIT: begin
              tmr_reg <= to_cycles(cmd_in.n, US_CYC);
              xs_reg  <= jss_pkg::JSS_X_WAIT;
            end
            jss_pkg::JSS_OP_TRST_ON:  trst_on_reg <= 1'b1;
            jss_pkg::JSS_OP_TRST_OFF: trst_on_reg <= 1'b0;
            jss_pkg::JSS_OP_RST_ON:   srst_on_reg <= 1'b1;
            jss_pkg::JSS_OP_RST_OFF:  srst_on_reg <= 1'b0;
            jss_pkg::JSS_OP_BURST_HI, jss_pkg::JSS_OP_BURST_LO: begin
              if (cmd_in.n != 16'h0000) begin
                xs_reg <= jss_pkg::JSS_X_BURST;
              end
            end
            jss_pkg::JSS_OP_END: begin
              script_reg <= 1'b0;
              xs_reg     <= jss_pkg::JSS_X_IDLE;
            end
            default: err_reg <= 1'b1;
          endcase
        end
        jss_pkg::JSS_X_WAIT: begin
          if (tmr_zero) begin
            xs_reg <= jss_pkg::JSS_X_FETCH;
          end
        end
        jss_pkg::JSS_X_BURST: begin
          if (done_reg) begin
            cnt_reg <= cnt_reg + 16'h0001;
            if (shift_end) begin
              xs_reg <= cmd_next ? jss_pkg::JSS_X_FETCH :
                                   jss_pkg::JSS_X_IDLE;
            end
          end
        end
        jss_pkg::JSS_X_SCAN: begin
          if (done_reg) begin
            cnt_reg <= cnt_reg + 16'h0001;
            if (seg_reg == 2'h0 && cnt_reg == hdr_last) begin
              seg_reg <= 2'h1;
              cnt_reg <= 16'h0000;
            end else if (seg_reg == 2'h1) begin
              sh_reg  <= {1'b0, sh_reg[31:1]};
              cap_reg <= {cap_bit_reg, cap_reg[31:1]};
              if (shift_end) begin
                seg_reg <= 2'h2;
                cnt_reg <= 16'h0000;
              end else if (script_reg && cnt_reg[4:0] == 5'h1F) begin
                xs_reg <= jss_pkg::JSS_X_LD;
              end
            end else if (seg_reg == 2'h2 &&
                         cnt_reg == 16'(`JSS_TAIL_LEN - 1)) begin
              if (script_reg) begin
                xs_reg <= jss_pkg::JSS_X_FETCH;
              end else if (phase_reg == jss_pkg::JSS_PH_CHECK) begin
                if (step_reg == 3'h1) begin
                  report_reg.bypass_ok <= cap_reg[1:0] == 2'h2;
                end
                if (step_reg == 3'h3) begin
                  report_reg.idcode <= cap_reg;
                end
                if (step_reg == 3'h5) begin
                  report_reg.dbg_ok <= cap_reg != 32'hFFFF_FFFF;
                end
                if (step_reg == last_step) begin
                  xs_reg    <= jss_pkg::JSS_X_IDLE;
                  phase_reg <= jss_pkg::JSS_PH_REL;
                end else begin
                  step_reg <= step_reg + 3'h1;
                  xs_reg   <= jss_pkg::JSS_X_DEC;
                end
              end else begin
                xs_reg <= jss_pkg::JSS_X_IDLE;
              end
            end
          end
        end
      endcase
      if (x_idle) begin
        unique case (phase_reg)
          jss_pkg::JSS_PH_IDLE, jss_pkg::JSS_PH_DONE: begin
            if (start) begin
              err_reg     <= 1'b0;
              srst_on_reg <= cfg.hard_reset;
              trst_on_reg <= 1'b1;
              tmr_reg     <= TRST_CYC;
              phase_reg   <= jss_pkg::JSS_PH_TRST;
            end
          end
          jss_pkg::JSS_PH_TRST: begin
            if (tmr_zero) begin
              trst_on_reg <= 1'b0;
              tmr_reg     <= cfg.hard_reset ?
                             to_cycles(cfg.reset_ms, MS_CYCLES) :
                             32'h0000_0000;
              phase_reg   <= jss_pkg::JSS_PH_HOLD;
            end
          end
          jss_pkg::JSS_PH_HOLD: begin
            if (tmr_zero) begin
              pc_reg     <= PRE_BASE;
              script_reg <= cfg.pre_en;
              xs_reg     <= cfg.pre_en ? jss_pkg::JSS_X_FETCH :
                                         jss_pkg::JSS_X_IDLE;
              phase_reg  <= jss_pkg::JSS_PH_PRE;
            end
          end
          jss_pkg::JSS_PH_PRE: begin
            script_reg <= 1'b0;
            step_reg   <= 3'h0;
            xs_reg     <= jss_pkg::JSS_X_DEC;
            phase_reg  <= jss_pkg::JSS_PH_CHECK;
          end
          jss_pkg::JSS_PH_REL: begin
            if (cfg.hard_reset) begin
              srst_on_reg <= 1'b0;
            end
            phase_reg <= jss_pkg::JSS_PH_SEE;
          end
          jss_pkg::JSS_PH_SEE: begin
            if (srst_seen) begin
              tmr_reg   <= to_cycles(cfg.wakeup_ms, MS_CYCLES);
              phase_reg <= jss_pkg::JSS_PH_WAKE;
            end
          end
          jss_pkg::JSS_PH_WAKE: begin
            if (tmr_zero && cfg.post_en) begin
              pc_reg     <= POST_BASE;
              script_reg <= 1'b1;
              xs_reg     <= jss_pkg::JSS_X_FETCH;
              phase_reg  <= jss_pkg::JSS_PH_POST;
            end else if (tmr_zero) begin
              // standard post part: settle the tap with one idle clock
              cur_reg   <= '{jss_pkg::JSS_OP_BURST_LO, 16'h0001,
                             32'h0000_0000};
              cnt_reg   <= 16'h0000;
              xs_reg    <= jss_pkg::JSS_X_BURST;
              phase_reg <= jss_pkg::JSS_PH_STD;
            end
          end
          jss_pkg::JSS_PH_POST, jss_pkg::JSS_PH_STD: begin
            script_reg <= 1'b0;
            phase_reg  <= jss_pkg::JSS_PH_DONE;
          end
          default: phase_reg <= jss_pkg::JSS_PH_IDLE;
        endcase
      end
    end
  end
endmodule

// ==== verif/jss_seq_props.sv ====
// port assertions for the jtag scan sequencer
`timescale 1ns/100ps
module jss_seq_props #(
  parameter logic [31:0] MS_CYCLES = 32'd40000
) (
  input wire logic                 clk_sys,
  input wire logic                 reset_n,
  input wire jss_pkg::jss_cfg_t    cfg,
  input wire logic                 start,
  input wire logic                 srst_n_i,
  input wire jss_pkg::jss_jtag_t   jtag,
  input wire logic                 trst_n_o,
  input wire logic                 trst_n_oe,
  input wire logic                 srst_n_oe,
  input wire logic                 seq_busy,
  input wire logic                 seq_done,
  input wire logic                 script_err,
  input wire jss_pkg::jss_report_t report
);
  logic rel_reg;
  int   hold_reg;
  int   wake_reg;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // lower bounds on the quiet spans before tck may run again
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rel_reg  <= 1'b0;
      hold_reg <= 0;
      wake_reg <= 0;
    end else begin
      rel_reg  <= !(start || $rose(jtag.tck)) &&
                  (rel_reg || $fell(srst_n_oe));
      hold_reg <= srst_n_oe ? hold_reg + 1 : 0;
      wake_reg <= srst_n_i ? wake_reg + 1 : 0;
    end
  end
  a_trst_oe_mode: assert property (
    trst_n_oe == (!trst_n_o || cfg.trst_push_pull))
    else $error("trst enable wrong");
  a_tck_high_len: assert property (
    $rose(jtag.tck) |-> jtag.tck [*4])
    else $error("tck high too short");
  a_pins_hold: assert property (
    jtag.tck && $past(jtag.tck) |-> $stable(jtag.tms) && $stable(jtag.tdi))
    else $error("tms or tdi moved while tck high");
  a_reset_hold: assert property (
    $rose(jtag.tck) && srst_n_oe |->
      hold_reg >= cfg.reset_ms * MS_CYCLES + 40)
    else $error("tck during reset hold");
  a_wake_delay: assert property (
    $rose(jtag.tck) && rel_reg |-> wake_reg >= cfg.wakeup_ms * MS_CYCLES)
    else $error("tck before wake-up delay");
  a_done_holds: assert property (
    seq_done && !start |=> seq_done)
    else $error("done dropped");
  a_err_sticky: assert property (
    script_err && !start |=> script_err)
    else $error("error flag dropped");
  a_report_quiet: assert property (
    !seq_busy && !start |=> $stable(report))
    else $error("report moved while idle");
  c_done: cover property ($rose(seq_done));
  c_err: cover property ($rose(script_err));
  c_rel: cover property ($fell(srst_n_oe));
endmodule
bind jss_sequencer jss_seq_props #(.MS_CYCLES(MS_CYCLES)) u_jss_seq_props (
  .clk_sys, .reset_n, .cfg, .start, .srst_n_i, .jtag, .trst_n_o,
  .trst_n_oe, .srst_n_oe, .seq_busy, .seq_done, .script_err, .report);

// ==== verif/jss_tap_model.sv ====
// behavioural target tap and system reset line
`timescale 1ns/100ps
`include "jss_regs.svh"
module jss_tap_model #(
  parameter logic [31:0] ID = 32'h00000001  // arbitrary value
) (
  input  wire logic               clk_sys,
  input  wire jss_pkg::jss_jtag_t jtag,
  input  wire logic               trst_n_o,
  input  wire logic               trst_n_oe,
  input  wire logic               srst_n_o,
  input  wire logic               srst_n_oe,
  input  wire logic [7:0]         rel_hold,
  output logic                    tdo = 1'b0,
  output logic                    srst_n_i,
  output logic [4:0]              ir_q = 5'h1F,
  output logic [31:0]             dr_upd = 32'h0,
  output int                      ones = 0,
  output int                      zeros = 0,
  output logic                    cau = 1'b0
);
  // next tap state for tms high and low, one nibble per state
  localparam logic [63:0] NX1 = 64'h2FEFCC0287855920;
  localparam logic [63:0] NX0 = 64'h1BDDBBA146644311;
  logic [3:0]  st    = 4'h0;
  logic [4:0]  ir_sh = 5'h00;
  logic [31:0] dr    = 32'h0;
  logic        byp   = 1'b0;
  logic [7:0]  hold  = 8'h00;
  wire         trst  = trst_n_oe ? trst_n_o : 1'b1;  // pull-up
  wire         rst_on = srst_n_oe && !srst_n_o;
  wire         bsel  = &ir_q;
  // target may keep reset low a while after the probe lets go
  always @(posedge clk_sys)
    hold <= rst_on ? rel_hold : (hold != 8'h00) ? hold - 8'h01 : 8'h00;
  assign srst_n_i = !rst_on && hold == 8'h00;
  always @(posedge jtag.tck or negedge trst) begin
    if (!trst) begin
      st <= 4'h0;
      ir_q <= 5'h1F;
    end else begin
      if (jtag.tms) ones <= ones + 1;
      else zeros <= zeros + 1;
      case (st)
        4'h3: dr <= (ir_q == 5'(`JSS_IDCODE_IR)) ? ID : 32'h0;
        4'h4: dr <= {jtag.tdi, dr[31:1]};
        4'h8: if (!bsel) dr_upd <= dr;
        4'hA: ir_sh <= 5'h01;
        4'hB: ir_sh <= {jtag.tdi, ir_sh[4:1]};
        4'hF: ir_q <= ir_sh;
        default: ;
      endcase
      byp <= (st == 4'h4) && jtag.tdi;
      if (st == 4'h8 && ir_q == 5'(`JSS_CATCH_IR))
        cau <= !srst_n_i && dr == `JSS_CATCH_MASK;
      st <= jtag.tms ? NX1[st*4 +: 4] : NX0[st*4 +: 4];
    end
  end
  // a released tdo never repeats its last bit
  always @(negedge jtag.tck)
    tdo <= (st == 4'h4) ? (bsel ? byp : dr[0]) :
           (st == 4'hB) ? ir_sh[0] : ~tdo;
endmodule

// ==== verif/jtag_scan_sequencer_tb.sv ====
// self-checking bench for the jtag scan sequencer
`timescale 1ns/100ps
`include "jss_regs.svh"
module jtag_scan_sequencer_tb;
  typedef struct {
    logic [31:0] id, bo, dbg, err, cau, ir, dr, o1, z0, ri;
  } jss_note_t;
  localparam logic [31:0] TGT_ID = 32'h0A5AC3E1;  // arbitrary value
  logic                 clk_sys = 1'b0;
  logic                 reset_n = 1'b0;
  logic                 start = 1'b0;
  logic                 load_we = 1'b0;
  logic [7:0]           load_addr = 8'h00;
  logic [31:0]          load_data = 32'h0;
  logic [7:0]           rel_hold = 8'h1E;
  jss_pkg::jss_cfg_t    cfg = '0;
  jss_pkg::jss_jtag_t   jtag;
  jss_pkg::jss_report_t report;
  logic                 tdo, srst_n_i, trst_n_o, trst_n_oe, srst_n_o;
  logic                 srst_n_oe, seq_busy, seq_done, script_err, cau;
  logic [4:0]           ir_q;
  logic [31:0]          dr_upd, rnd_ir, rnd_dr;
  logic [31:0]          scr[$];
  logic [7:0]           pc;
  int                   ones, zeros, rises = 0, seed = 8818;
  int                   miscompares = 0, check_count = 0;
  jss_note_t            notes[$];
  initial forever #12.5 clk_sys = ~clk_sys;
  jss_sequencer #(.MS_CYCLES(32'd40)) u_jss_sequencer (
    .clk_sys, .reset_n, .cfg, .start, .load_we, .load_addr, .load_data,
    .tdo, .srst_n_i, .jtag, .trst_n_o, .trst_n_oe, .srst_n_o, .srst_n_oe,
    .seq_busy, .seq_done, .script_err, .report);
  jss_tap_model #(.ID(TGT_ID)) u_jss_tap_model (
    .clk_sys, .jtag, .trst_n_o, .trst_n_oe, .srst_n_o, .srst_n_oe,
    .rel_hold, .tdo, .srst_n_i, .ir_q, .dr_upd, .ones, .zeros, .cau);
  always @(posedge srst_n_oe) rises++;
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] cw(input logic [3:0] op,
                                    input logic [15:0] n);
    return {op, 12'h000, n};
  endfunction
  task automatic load(input logic [7:0] base);
    pc = base;
    foreach (scr[i]) begin
      @(posedge clk_sys) #2;
      load_we = 1'b1;
      load_addr = pc;
      load_data = scr[i];
      pc++;
    end
  endtask
  // poke gives a second start mid-run, which must change nothing
  task automatic run(input jss_note_t n, input bit poke);
    @(posedge clk_sys) #2;
    load_we = 1'b0;
    notes.push_back(n);
    start = 1'b1;
    @(posedge clk_sys) #2 start = 1'b0;
    if (poke) begin
      repeat (300) @(posedge clk_sys);
      #2 start = 1'b1;
      @(posedge clk_sys) #2 start = 1'b0;
    end
    for (int i = 0; i < 30000 && seq_done !== 1'b1; i++) @(posedge clk_sys);
    if (seq_done !== 1'b1) begin
      miscompares++;
      $display("[FAIL] %0t sequence timed out", $time);
    end
    @(posedge clk_sys) #2;
  endtask
  always @(posedge seq_done) begin
    jss_note_t n;
    #1;
    if (notes.size() == 0) begin
      miscompares++;
      $display("[FAIL] %0t result without a pending note", $time);
    end else begin
      n = notes.pop_front();
      chk(report.idcode, n.id);
      chk(32'(report.bypass_ok), n.bo);
      chk(32'(report.dbg_ok), n.dbg);
      chk(32'(script_err), n.err);
      chk(32'(cau), n.cau);
      chk(32'(ir_q), n.ir);
      chk(dr_upd, n.dr);
      chk(ones, n.o1);
      chk(zeros, n.z0);
      chk(rises, n.ri);
      chk(32'(seq_busy), 32'h0);
    end
  end
  initial begin
    #2000000;
    miscompares++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim();
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    #2 reset_n = 1'b1;
    // hard reset with catch, both scripts, slow reset release
    rnd_ir = 32'($random(seed)) & 32'h7;
    rnd_dr = $random(seed);
    cfg = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 16'h0002, 16'h0002};
    scr = '{cw(4'h9, 16'h1), cw(4'h4, 16'h0), cw(4'h3, 16'h2),
            cw(4'h5, 16'h0), cw(4'h9, 16'h1), cw(4'h9, 16'h3),
            cw(4'h8, 16'h5), cw(4'h9, 16'h1), cw(4'h0, 16'h0)};
    load(8'h00);
    scr = '{cw(4'h1, 16'h5), rnd_ir, cw(4'h2, 16'h20), rnd_dr,
            cw(4'h9, 16'h2), cw(4'h6, 16'h0), cw(4'h7, 16'h0),
            cw(4'h0, 16'h0)};
    load(8'h80);
    // ones 5+28+7, zeros 6+164+43 over pre, checks and post
    run('{TGT_ID, 1, 1, 0, 1, rnd_ir, rnd_dr, ones + 40, zeros + 213,
          rises + 2}, 1'b1);
    $display("test 1 finished");
    // no hard reset, refused scans and op, standard post part
    cfg = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 16'h0002, 16'h0001};
    rel_hold = 8'h00;
    scr = '{cw(4'h9, 16'h1), cw(4'h2, 16'h0), cw(4'h1, 16'h101)};
    repeat (9) scr.push_back($random(seed));
    scr.push_back(cw(4'hA, 16'h0));
    scr.push_back(cw(4'h0, 16'h0));
    load(8'h00);
    run('{TGT_ID, 1, 1, 1, 1, 5'(`JSS_DBG_IR), 32'h1 << `JSS_HALT_BIT,
          ones + 21, zeros + 125, rises}, 1'b0);
    $display("test 2 finished");
    end_sim();
  end
endmodule
